// ===== cma_accum.sv
`timescale 1ns/1ns
`include "cma_map.svh"
module cma_accum
#(
    parameter int ACC_W = 32
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // accepted result
    input  wire logic             res_valid,
    input  wire logic [15:0]      res_data,
    input  wire logic             twos,
    // control
    input  wire cma_pkg::cma_acc_t acc_mode,
    input  wire logic             clr,
    // total
    output logic      [ACC_W-1:0] total
);
    import cma_pkg::*;

    wire logic [ACC_W-1:0] ext = twos ? ACC_W'($signed(res_data)) : ACC_W'(res_data);
    // no overflow flag: the total simply wraps
    wire logic [ACC_W-1:0] next_total = clr ? '0 :
        !res_valid ? total :
        acc_mode == ACC_ADD ? ACC_W'(total + ext) :
        acc_mode == ACC_SUB ? ACC_W'(total - ext) : total;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            total <= `CMA_RST_ACCUM;
        else
            total <= next_total;
    end

    chk_acc_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clr |=> total == '0)
        else $error("accumulator not cleared");
    chk_acc_add: assert property (@(posedge sys_clk) disable iff (rst)
        !clr && res_valid && acc_mode == ACC_ADD |=> total == ACC_W'($past(total) + $past(ext)))
        else $error("accumulator add wrong");
endmodule // cma_accum

// ===== cma_map.svh
`ifndef CMA_MAP_SVH
`define CMA_MAP_SVH

// register byte addresses (one aligned 32-bit word each)
`define CMA_OFF_STATUS      32'hFFFF0500
`define CMA_OFF_POST_CFG    32'hFFFF0504
`define CMA_OFF_MODE_CTRL   32'hFFFF0508
`define CMA_OFF_CUR_CTRL    32'hFFFF050C
`define CMA_OFF_FILTER_CTRL 32'hFFFF0510
`define CMA_OFF_THRESHOLD   32'hFFFF0550
`define CMA_OFF_THR_LIMIT   32'hFFFF0554
`define CMA_OFF_THR_COUNT   32'hFFFF0558
`define CMA_OFF_ACCUM       32'hFFFF055C
`define CMA_OFF_REF_SCALE   32'hFFFF057C

// converter_mode_ctrl fields
`define CMA_MODE_CONV_MSB   2
`define CMA_MODE_CONV_LSB   0
`define CMA_MODE_PWR_MSB    4
`define CMA_MODE_PWR_LSB    3
`define CMA_MODE_REF_BIT    5

// converter_post_config fields
`define CMA_CFG_CMP_MSB     4
`define CMA_CFG_CMP_LSB     3
`define CMA_CFG_ACC_MSB     6
`define CMA_CFG_ACC_LSB     5

// current_channel_ctrl: set for unipolar result format
`define CMA_CUR_UNIPOLAR    12

// converter_status flag positions
`define CMA_STA_READY       0
`define CMA_STA_OVER        3
`define CMA_STA_COUNT       4

// reset values
`define CMA_RST_MODE        6'h00
`define CMA_RST_CFG         7'h00
`define CMA_RST_CUR_CTRL    16'h0000
`define CMA_RST_FILTER      16'h0007
`define CMA_RST_THRESHOLD   16'h0000
`define CMA_RST_LIMIT       8'h01
`define CMA_RST_ACCUM       32'h00000000

`endif

// ===== cma_pkg.sv
package cma_pkg;

    typedef enum logic [2:0] {
        CONV_OFF    = 3'h0,
        CONV_CONT   = 3'h1,
        CONV_SINGLE = 3'h2,
        CONV_IDLE   = 3'h3
    } cma_conv_t;

    typedef enum logic [1:0] {
        PWR_NORMAL  = 2'h0,
        PWR_LOW     = 2'h1,
        PWR_LOWPLUS = 2'h2
    } cma_pwr_t;

    typedef enum logic [1:0] {
        CMP_OFF     = 2'h0,
        CMP_OVER    = 2'h1,
        CMP_CNT_DEC = 2'h2,
        CMP_CNT_CLR = 2'h3
    } cma_cmp_t;

    typedef enum logic [1:0] {
        ACC_OFF     = 2'h0,
        ACC_ADD     = 2'h1,
        ACC_SUB     = 2'h2
    } cma_acc_t;

    typedef enum logic [3:0] {
        ST_OFF    = 4'b0001,
        ST_IDLE   = 4'b0010,
        ST_CONT   = 4'b0100,
        ST_SINGLE = 4'b1000
    } cma_state_t;

endpackage

// ===== cma_threshold.sv
`timescale 1ns/1ns
module cma_threshold
#(
    parameter int CNT_W = 8
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // accepted result
    input  wire logic             res_valid,
    input  wire logic [15:0]      res_data,
    input  wire logic             twos,
    // settings
    input  wire logic [15:0]      level,
    input  wire logic [CNT_W-1:0] limit,
    input  wire cma_pkg::cma_cmp_t cmp_mode,
    input  wire logic             clr,
    // state and events
    output logic      [CNT_W-1:0] count,
    output logic                  over_hit,
    output logic                  count_hit
);
    import cma_pkg::*;

    // -32768 gives 0x8000, which still compares correctly against a 15-bit level
    wire logic [15:0]      mag         = (twos && res_data[15]) ? 16'(~res_data + 16'h0001)
                                                                 : res_data;
    wire logic [15:0]      lvl         = twos ? {1'b0, level[14:0]} : level;
    wire logic             at_or_above = mag >= lvl;
    wire logic             cnt_on      = (cmp_mode == CMP_CNT_DEC) || (cmp_mode == CMP_CNT_CLR);
    wire logic             cnt_full    = count == {CNT_W{1'b1}};
    wire logic [CNT_W-1:0] cnt_up      = cnt_full ? count : CNT_W'(count + 1'b1);
    wire logic [CNT_W-1:0] cnt_down    = (cmp_mode == CMP_CNT_DEC && count != '0)
                                         ? CNT_W'(count - 1'b1) : '0;
    wire logic [CNT_W-1:0] next_count  = (clr || !cnt_on) ? '0 :
                                         !res_valid ? count :
                                         at_or_above ? cnt_up : cnt_down;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count     <= '0;
            over_hit  <= 1'b0;
            count_hit <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            over_hit  <= res_valid && cmp_mode == CMP_OVER && mag > lvl;
            count_hit <= res_valid && cnt_on && !clr && at_or_above
                         && !cnt_full && next_count == limit;
        end
    end

    chk_count_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clr |=> count == '0)
        else $error("threshold counter not cleared");
    chk_count_step: assert property (@(posedge sys_clk) disable iff (rst)
        res_valid && cnt_on && !clr && at_or_above && !cnt_full
        |=> count == CNT_W'($past(count) + 1'b1))
        else $error("threshold counter did not step up");
    chk_over_event: assert property (@(posedge sys_clk) disable iff (rst)
        res_valid && cmp_mode == CMP_OVER && mag > lvl |=> over_hit)
        else $error("over-threshold result raised no event");
endmodule // cma_threshold

// ===== cma_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "cma_map.svh"
module cma_top
#(
    parameter int CNT_W = 8,
    parameter int ACC_W = 32
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // current-channel results from the filter
    input  wire logic        res_valid,
    input  wire logic [15:0] res_data,
    // factory trim for the reference scale
    input  wire logic [15:0] ref_scale_factory,
    // converter analog controls
    output logic             cur_chan_on,
    output logic             cur_convert,
    output logic             vt_convert,
    output logic             mod_clk_lp,
    output logic             gain_fixed_128,
    output logic             gain_fixed_512,
    output logic             ref_precise,
    output logic      [15:0] filter_ctrl,
    output logic      [15:0] cur_ctrl,
    // converter event request
    output logic             conv_irq
);
    import cma_pkg::*;
    default clocking cma_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = a == off;
    endfunction

    function automatic logic [2:0] conv_code(input cma_state_t s);
        case (s)
            ST_IDLE:   conv_code = CONV_IDLE;
            ST_CONT:   conv_code = CONV_CONT;
            ST_SINGLE: conv_code = CONV_SINGLE;
            default:   conv_code = CONV_OFF;
        endcase
    endfunction

    // register state
    logic [2:0]        mode_hi;
    logic [6:0]        post_cfg;
    logic [15:0]       threshold;
    logic [CNT_W-1:0]  count_limit;
    logic [15:0]       ref_scale;
    logic [2:0]        status;
    cma_state_t        state;
    cma_state_t        next_state;
    logic [CNT_W-1:0]  thr_count;
    logic [ACC_W-1:0]  acc_total;
    logic              over_hit;
    logic              count_hit;

    // address decode
    wire logic sel_sta = hit(reg_addr, `CMA_OFF_STATUS);
    wire logic sel_cfg = hit(reg_addr, `CMA_OFF_POST_CFG);
    wire logic sel_mde = hit(reg_addr, `CMA_OFF_MODE_CTRL);
    wire logic sel_con = hit(reg_addr, `CMA_OFF_CUR_CTRL);
    wire logic sel_flt = hit(reg_addr, `CMA_OFF_FILTER_CTRL);
    wire logic sel_th  = hit(reg_addr, `CMA_OFF_THRESHOLD);
    wire logic sel_tcl = hit(reg_addr, `CMA_OFF_THR_LIMIT);
    wire logic sel_thv = hit(reg_addr, `CMA_OFF_THR_COUNT);
    wire logic sel_acc = hit(reg_addr, `CMA_OFF_ACCUM);
    wire logic sel_ref = hit(reg_addr, `CMA_OFF_REF_SCALE);

    wire logic wr_mde = reg_wr && sel_mde;
    wire logic wr_con = reg_wr && sel_con;
    // either write reconfigures the current channel
    wire logic reconfig = wr_mde || wr_con;

    wire cma_pwr_t pwr = cma_pwr_t'(mode_hi[1:0]);
    wire logic low_pwr = pwr != PWR_NORMAL;
    wire cma_cmp_t cmp_mode = cma_cmp_t'(post_cfg[`CMA_CFG_CMP_MSB:`CMA_CFG_CMP_LSB]);
    wire cma_acc_t acc_mode = cma_acc_t'(post_cfg[`CMA_CFG_ACC_MSB:`CMA_CFG_ACC_LSB]);
    wire logic acc_off  = acc_mode != ACC_ADD && acc_mode != ACC_SUB;
    wire logic twos     = !cur_ctrl[`CMA_CUR_UNIPOLAR];
    wire logic running  = state == ST_CONT || state == ST_SINGLE;
    // results arriving while stopped or during a rewrite are dropped
    wire logic res_take = res_valid && running && !reconfig;

    // conversion state follows mode writes; a single conversion ends itself
    wire cma_conv_t conv_wr = cma_conv_t'(reg_wdata[`CMA_MODE_CONV_MSB:`CMA_MODE_CONV_LSB]);
    always_comb
    begin
        next_state = state;
        if (wr_mde)
        begin
            case (conv_wr)
                CONV_IDLE:   next_state = ST_IDLE;
                CONV_CONT:   next_state = ST_CONT;
                CONV_SINGLE: next_state = ST_SINGLE;
                default:     next_state = ST_OFF;
            endcase
        end
        else if (state == ST_SINGLE && res_take)
            next_state = ST_OFF;
    end

    // status flags clear on a status read; a set in the same cycle wins
    wire logic       sta_clr = reg_rd && sel_sta;
    wire logic [2:0] sta_set = {count_hit, over_hit, res_take};
    wire logic [2:0] next_status = sta_set | (status & {3{!sta_clr}});

    // read mux, unmapped addresses read zero
    wire logic [31:0] rd_mux =
        ({32{sel_sta}} & 32'({status[2], status[1], 2'b00, status[0]})) |
        ({32{sel_cfg}} & 32'(post_cfg)) |
        ({32{sel_mde}} & 32'({mode_hi, conv_code(state)})) |
        ({32{sel_con}} & 32'(cur_ctrl)) |
        ({32{sel_flt}} & 32'(filter_ctrl)) |
        ({32{sel_th}}  & 32'(threshold)) |
        ({32{sel_tcl}} & 32'(count_limit)) |
        ({32{sel_thv}} & 32'(thr_count)) |
        ({32{sel_acc}} & 32'(acc_total)) |
        ({32{sel_ref}} & 32'(ref_scale));

    // analog controls, registered so the pins never glitch on decode
    wire logic next_cur_on   = state != ST_OFF;
    wire logic next_vt_conv  = running && !low_pwr;
    wire logic next_clk_lp   = low_pwr;
    wire logic next_gain_128 = pwr == PWR_LOW;
    wire logic next_gain_512 = pwr == PWR_LOWPLUS;
    // normal mode always runs from the precision reference
    wire logic next_ref_prec = !low_pwr || mode_hi[2];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state          <= ST_OFF;
            mode_hi        <= 3'(`CMA_RST_MODE >> 3);
            post_cfg       <= `CMA_RST_CFG;
            cur_ctrl       <= `CMA_RST_CUR_CTRL;
            filter_ctrl    <= `CMA_RST_FILTER;
            threshold      <= `CMA_RST_THRESHOLD;
            count_limit    <= CNT_W'(`CMA_RST_LIMIT);
            ref_scale      <= ref_scale_factory;
            status         <= 3'h0;
            reg_rdata      <= 32'h00000000;
            cur_chan_on    <= 1'b0;
            cur_convert    <= 1'b0;
            vt_convert     <= 1'b0;
            mod_clk_lp     <= 1'b0;
            gain_fixed_128 <= 1'b0;
            gain_fixed_512 <= 1'b0;
            ref_precise    <= 1'b1;
            conv_irq       <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            status         <= next_status;
            reg_rdata      <= reg_rd ? rd_mux : 32'h00000000;
            cur_chan_on    <= next_cur_on;
            cur_convert    <= running;
            vt_convert     <= next_vt_conv;
            mod_clk_lp     <= next_clk_lp;
            gain_fixed_128 <= next_gain_128;
            gain_fixed_512 <= next_gain_512;
            ref_precise    <= next_ref_prec;
            conv_irq       <= next_status[2] || next_status[1];
            if (wr_mde)
                mode_hi <= reg_wdata[`CMA_MODE_REF_BIT:`CMA_MODE_PWR_LSB];
            if (reg_wr && sel_cfg)
                post_cfg <= reg_wdata[6:0];
            if (wr_con)
                cur_ctrl <= reg_wdata[15:0];
            if (reg_wr && sel_flt)
                filter_ctrl <= reg_wdata[15:0];
            if (reg_wr && sel_th)
                threshold <= reg_wdata[15:0];
            if (reg_wr && sel_tcl)
                count_limit <= reg_wdata[CNT_W-1:0];
            if (reg_wr && sel_ref)
                ref_scale <= reg_wdata[15:0];
        end
    end

    cma_threshold #(.CNT_W(CNT_W)) u_threshold
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .res_valid (res_take),
        .res_data  (res_data),
        .twos      (twos),
        .level     (threshold),
        .limit     (count_limit),
        .cmp_mode  (cmp_mode),
        .clr       (reconfig),
        .count     (thr_count),
        .over_hit  (over_hit),
        .count_hit (count_hit)
    );

    cma_accum #(.ACC_W(ACC_W)) u_accum
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .res_valid (res_take),
        .res_data  (res_data),
        .twos      (twos),
        .acc_mode  (acc_mode),
        .clr       (reconfig || acc_off),
        .total     (acc_total)
    );

    chk_single_ends: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_SINGLE && res_take && !wr_mde |=> state == ST_OFF ##1 !cur_convert)
        else $error("single conversion did not power down");
    chk_lp_gain: assert property (@(posedge sys_clk) disable iff (rst)
        pwr == PWR_LOW && !wr_mde |=> gain_fixed_128 && !gain_fixed_512 && mod_clk_lp)
        else $error("low power gain or clock wrong");
    chk_lpp_gain: assert property (@(posedge sys_clk) disable iff (rst)
        pwr == PWR_LOWPLUS && !wr_mde |=> gain_fixed_512 && !vt_convert)
        else $error("low power-plus gain wrong");
    chk_reconfig_clr: assert property (@(posedge sys_clk) disable iff (rst)
        reconfig ##1 !res_take ##1 reg_rd && sel_acc |=> reg_rdata == 32'h00000000)
        else $error("accumulator survived reconfiguration");
    chk_flag_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        sta_clr && over_hit |=> status[1] && conv_irq)
        else $error("over-threshold flag lost on clear");

    // register port and status flags
    chk_rdata_idle: assert property
        (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data not idle");
    chk_ready_flag: assert property
        (res_take |=> status[0])
        else $error("ready flag not set");
    chk_over_sticky: assert property
        (status[1] && !sta_clr |=> status[1])
        else $error("over flag dropped");
    chk_over_flag: assert property
        (over_hit |=> status[1] && conv_irq)
        else $error("over flag not raised");
    chk_count_flag: assert property
        (count_hit |=> status[2] && conv_irq)
        else $error("count flag not raised");

    // mode register and conversion state
    chk_mode_field: assert property
        (wr_mde |=> mode_hi == $past(reg_wdata[`CMA_MODE_REF_BIT:`CMA_MODE_PWR_LSB]))
        else $error("mode field not stored");
    chk_conv_start: assert property
        (wr_mde && conv_wr == CONV_CONT |=> state == ST_CONT)
        else $error("continuous mode not entered");
    chk_off_down: assert property
        (state == ST_OFF && !wr_mde |=> !cur_chan_on && !cur_convert)
        else $error("channel not powered down");
    chk_drop_stopped: assert property
        (!running && res_valid && !reconfig && !acc_off |=> acc_total == $past(acc_total))
        else $error("result taken while stopped");

    // analog controls per power mode, and the reference scale write
    chk_normal_mode: assert property
        (pwr == PWR_NORMAL && !wr_mde
            |=> !mod_clk_lp && ref_precise && !gain_fixed_128 && !gain_fixed_512)
        else $error("normal mode controls wrong");
    chk_normal_vt: assert property
        (pwr == PWR_NORMAL && running && !wr_mde |=> vt_convert)
        else $error("voltage channel idle in normal mode");
    chk_lp_no_vt: assert property
        (low_pwr && !wr_mde |=> !vt_convert)
        else $error("voltage channel on in low power");
    chk_lp_ref: assert property
        (low_pwr && !wr_mde |=> ref_precise == mode_hi[2])
        else $error("low power reference select wrong");
    chk_ref_write: assert property
        (reg_wr && sel_ref |=> ref_scale == $past(reg_wdata[15:0]))
        else $error("reference scale not written");
endmodule // cma_top

// ===== cma_top_tb.sv
`timescale 1ns/1ns
`include "cma_map.svh"
module cma_top_tb;
    import cma_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        res_valid = 1'b0;
    logic [15:0] res_data = 16'h0;
    logic [15:0] ref_scale_factory = 16'h7EB9;
    logic        cur_chan_on, cur_convert, vt_convert, mod_clk_lp;
    logic        gain_fixed_128, gain_fixed_512, ref_precise, conv_irq;
    logic [15:0] filter_ctrl, cur_ctrl;
    int          bad_count = 0;
    int          check_count = 0;
    logic [31:0] seed = 32'h2DACD95F;
    // behavioural model of the register view
    logic [31:0] m_acc = 32'h0;
    int          m_cnt = 0;
    int          m_lim = 1;
    int          m_thr = 0;
    logic [6:0]  m_cfg = 7'h00;
    logic [5:0]  m_mode = 6'h00;
    logic [2:0]  m_st = 3'h0;
    logic        m_uni = 1'b0;
    logic        m_rdy = 1'b0;
    logic        m_ovr = 1'b0;
    logic        m_hit = 1'b0;
    logic [15:0] vals [8] = '{16'h20, 16'h20, 16'h05, 16'h20, 16'h20, 16'h20, 16'h20, 16'h05};

    cma_top i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res_valid(res_valid),
        .res_data(res_data), .ref_scale_factory(ref_scale_factory),
        .cur_chan_on(cur_chan_on), .cur_convert(cur_convert), .vt_convert(vt_convert),
        .mod_clk_lp(mod_clk_lp), .gain_fixed_128(gain_fixed_128),
        .gain_fixed_512(gain_fixed_512), .ref_precise(ref_precise),
        .filter_ctrl(filter_ctrl), .cur_ctrl(cur_ctrl), .conv_irq(conv_irq));

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic finish_test();
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // model: a write lands at the strobe edge; mode or channel writes reconfigure
    function automatic void mdl_write(input logic [31:0] a, input logic [31:0] d);
        if (a == `CMA_OFF_MODE_CTRL || a == `CMA_OFF_CUR_CTRL)
        begin
            m_acc = 32'h0;
            m_cnt = 0;
        end
        if (a == `CMA_OFF_MODE_CTRL)
        begin
            m_mode = d[5:0];
            m_st = d[2:0];
        end
        if (a == `CMA_OFF_CUR_CTRL) m_uni = d[12];
        if (a == `CMA_OFF_POST_CFG) m_cfg = d[6:0];
        if (m_cfg[4:3] < 2'h2) m_cnt = 0;
        if (a == `CMA_OFF_THRESHOLD) m_thr = int'(d[15:0]);
        if (a == `CMA_OFF_THR_LIMIT) m_lim = int'(d[7:0]);
        if (m_cfg[6:5] == 2'h0 || m_cfg[6:5] == 2'h3) m_acc = 32'h0;
    endfunction

    function automatic void mdl_res(input logic [15:0] d);
        int mag;
        int thr;
        if (m_st != 3'h1 && m_st != 3'h2) return;
        mag = m_uni ? int'(d) : (d[15] ? 65536 - int'(d) : int'(d));
        thr = m_uni ? m_thr : m_thr % 32768;
        m_rdy = 1'b1;
        if (m_cfg[6:5] == 2'h1) m_acc = m_acc + (m_uni ? {16'h0, d} : {{16{d[15]}}, d});
        if (m_cfg[6:5] == 2'h2) m_acc = m_acc - (m_uni ? {16'h0, d} : {{16{d[15]}}, d});
        if (m_cfg[4:3] == 2'h1 && mag > thr) m_ovr = 1'b1;
        if (m_cfg[4:3] >= 2'h2)
        begin
            if (mag >= thr)
            begin
                if (m_cnt < 255)
                begin
                    m_cnt++;
                    if (m_cnt == m_lim) m_hit = 1'b1;
                end
            end
            else if (m_cfg[4:3] == 2'h2)
            begin
                if (m_cnt > 0) m_cnt--;
            end
            else
                m_cnt = 0;
        end
        if (m_st == 3'h2) m_st = 3'h0;
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        mdl_write(a, d);
    endtask

    task automatic chk_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e & m, "read");
        if (a == `CMA_OFF_STATUS) {m_rdy, m_ovr, m_hit} = 3'b000;
    endtask

    task automatic res(input logic [15:0] d);
        @(posedge sys_clk);
        res_valid <= 1'b1;
        res_data <= d;
        @(posedge sys_clk);
        res_valid <= 1'b0;
        mdl_res(d);
    endtask

    // back-to-back results, valid held high across the whole burst
    task automatic burst(input int n);
        logic [15:0] d;
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            d = 16'(xs());
            res_valid <= 1'b1;
            res_data <= d;
            mdl_res(d);
        end
        @(posedge sys_clk);
        res_valid <= 1'b0;
    endtask

    task automatic pins(input logic [5:0] v);
        logic [1:0] p;
        p = v[4:3];
        wr(`CMA_OFF_MODE_CTRL, {26'h0, v});
        @(posedge sys_clk);
        #1;
        chk({cur_chan_on, cur_convert, vt_convert, mod_clk_lp, gain_fixed_128, gain_fixed_512,
            ref_precise}, {2'b11, p == 2'h0, p != 2'h0, p == 2'h1, p == 2'h2,
            p == 2'h0 || v[5]}, "power");
        burst(6);
        chk_reg(`CMA_OFF_STATUS, 32'h19, {27'h0, m_hit, m_ovr, 2'b00, m_rdy});
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, m_acc);
    endtask

    task automatic irq_check();
        repeat (4) @(posedge sys_clk);
        #1;
        chk({31'h0, conv_irq}, {31'h0, m_ovr | m_hit}, "irq");
        chk_reg(`CMA_OFF_STATUS, 32'h19, {27'h0, m_hit, m_ovr, 2'b00, m_rdy});
        repeat (4) @(posedge sys_clk);
        #1;
        chk({31'h0, conv_irq}, 32'h0, "irq clear");
    endtask

    initial
    begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({16'h0, filter_ctrl}, 32'h7, "filter");
        chk({30'h0, ref_precise, cur_chan_on}, 32'h2, "rst pins");
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, 32'h0);
        chk_reg(`CMA_OFF_REF_SCALE, 32'hFFFF, {16'h0, ref_scale_factory});
        chk_reg(`CMA_OFF_THR_LIMIT, 32'hFF, 32'h1);
        chk_reg(32'hFFFF0600, 32'hFFFFFFFF, 32'h0);
        wr(`CMA_OFF_ACCUM, 32'hFFFFFFFF);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, 32'h0);
        wr(`CMA_OFF_REF_SCALE, 32'h8000);
        chk_reg(`CMA_OFF_REF_SCALE, 32'hFFFF, 32'h8000);
        // start-up order; settle delays shortened since they bind software only
        wr(`CMA_OFF_CUR_CTRL, 32'h8007);
        wr(`CMA_OFF_MODE_CTRL, 32'h09);
        @(posedge sys_clk);
        #1;
        chk({16'h0, cur_ctrl}, 32'h8007, "cur ctrl");
        wr(`CMA_OFF_MODE_CTRL, 32'h03);
        wr(`CMA_OFF_POST_CFG, 32'h20);
        #1;
        chk({30'h0, cur_chan_on, cur_convert}, 32'h2, "idle");
        res(16'h0123);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, m_acc);
        foreach (vals[i]) pins(i[0] ? 6'h29 : 6'h01 + {i[2:1], 3'b000});
        pins(6'h31);
        // single conversion drops back to power-down by itself
        wr(`CMA_OFF_MODE_CTRL, 32'h02);
        @(posedge sys_clk);
        #1;
        chk({30'h0, cur_convert, vt_convert}, 32'h3, "single");
        res(16'h0040);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({31'h0, cur_chan_on}, 32'h0, "single off");
        chk_reg(`CMA_OFF_MODE_CTRL, 32'h7, {29'h0, m_st});
        res(16'h0040);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, m_acc);
        // subtract past zero wraps without complaint
        wr(`CMA_OFF_MODE_CTRL, 32'h01);
        wr(`CMA_OFF_POST_CFG, 32'h40);
        res(16'h0005);
        burst(20);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, m_acc);
        wr(`CMA_OFF_POST_CFG, 32'h00);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, 32'h0);
        wr(`CMA_OFF_POST_CFG, 32'h20);
        wr(`CMA_OFF_CUR_CTRL, 32'h1000);
        burst(9);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, m_acc);
        wr(`CMA_OFF_CUR_CTRL, 32'h1000);
        chk_reg(`CMA_OFF_ACCUM, 32'hFFFFFFFF, 32'h0);
        // strict compare, sign-free magnitude, threshold width by format
        wr(`CMA_OFF_POST_CFG, 32'h08);
        for (int k = 0; k < 5; k++)
        begin
            wr(`CMA_OFF_CUR_CTRL, k > 2 ? 32'h1000 : 32'h0);
            wr(`CMA_OFF_THRESHOLD, k > 1 ? 32'h8100 : 32'h0100);
            chk_reg(`CMA_OFF_STATUS, 32'h19, {27'h0, m_hit, m_ovr, 2'b00, m_rdy});
            res(k == 0 ? 16'h0100 : k == 1 ? 16'hFEFF : k == 3 ? 16'h8101 : 16'h0101);
            irq_check();
        end
        // result and status read in adjacent cycles: the set must win
        @(posedge sys_clk);
        res_valid <= 1'b1;
        res_data <= 16'hFFFF;
        @(posedge sys_clk);
        res_valid <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= `CMA_OFF_STATUS;
        mdl_res(16'hFFFF);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & 32'h19, 32'h1, "status race");
        m_rdy = 1'b0;
        irq_check();
        // threshold counter in decrement, then clear, configuration
        wr(`CMA_OFF_CUR_CTRL, 32'h0);
        wr(`CMA_OFF_THRESHOLD, 32'h10);
        wr(`CMA_OFF_THR_LIMIT, 32'h3);
        wr(`CMA_OFF_POST_CFG, 32'h10);
        foreach (vals[i])
        begin
            if (i == 6) wr(`CMA_OFF_POST_CFG, 32'h18);
            res(vals[i]);
            chk_reg(`CMA_OFF_THR_COUNT, 32'hFF, m_cnt);
        end
        irq_check();
        finish_test();
    end
endmodule // cma_top_tb
